/* logic/ibec_pkg.sv */
`default_nettype none
package ibec_pkg;
  // data path widths
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 16;
  localparam int TIM_W       = 8;
  localparam int UL_CNT_W    = 4;
  localparam int PULSE_CNT_W = 12;

  // pulse timing register: 10 MHz setting after reset, bit 7 read-only zero
  localparam logic [TIM_W-1:0] TIMING_RESET = 8'h7B;
  localparam logic [TIM_W-1:0] TIMING_WMASK = 8'h7F;

  // unlock key field and window length in instruction cycles
  localparam int                KEY_MSB       = 7;
  localparam int                KEY_LSB       = 2;
  localparam logic [5:0]        UNLOCK_KEY    = 6'h26;
  localparam logic [UL_CNT_W-1:0] UNLOCK_CYCLES = 4'h8;

  // start address in either memory after reset
  localparam logic [ADDR_W-1:0] START_ADDR = 16'h0000;

  // pulse width is timing value times 2**PULSE_SHIFT enabled clocks
  localparam int PULSE_SHIFT = 4;

  // load clock half period is LDCLK_HALF plus one enabled clocks
  localparam int              LDCLK_W    = 4;
  localparam logic [LDCLK_W-1:0] LDCLK_HALF = 4'h7;

  // least hold of the force level after reset release (host side)
  localparam int FORCE_HOLD_CYCLES = 3;

  // start selection sequence
  typedef enum logic [1:0] {
    IBEC_ST_SAMPLE = 2'b01,
    IBEC_ST_RUN    = 2'b10
  } ibec_start_st_t;

  // flash pulse generator
  typedef enum logic [1:0] {
    IBEC_PL_IDLE   = 2'b01,
    IBEC_PL_ACTIVE = 2'b10
  } ibec_pulse_st_t;
endpackage
`default_nettype wire

/* logic/ibec_unlock.sv */
`timescale 1ns/10ps
`default_nettype none
module ibec_unlock (
  input  wire logic                          clk_sys_i,     // system clock
  input  wire logic                          reset_i,       // sync reset
  input  wire logic                          clk_en_i,      // clock enable
  input  wire logic                          wr_i,          // unlock register write
  input  wire logic [ibec_pkg::BYTE_W-1:0]   wdata_i,       // write data
  input  wire logic                          instr_cycle_i, // instruction cycle strobe
  input  wire logic                          freeze_i,      // hold the window count
  output logic                               unlock_o,      // unlock bit
  output logic [ibec_pkg::UL_CNT_W-1:0]      count_o        // cycles left
);
  import ibec_pkg::*;

  logic [UL_CNT_W-1:0] cnt_q;
  logic                key_match;

  // only the upper six bits form the key, low two are don't care
  assign key_match = wr_i && (wdata_i[KEY_MSB:KEY_LSB] == UNLOCK_KEY);

  // window counter; a fresh match restarts it, a miss changes nothing
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (clk_en_i) begin
      if (key_match) begin
        cnt_q <= UNLOCK_CYCLES;
      end else if (cnt_q != '0 && instr_cycle_i && !freeze_i) begin
        // interrupts do not stop this count, only a breakpoint or a low clock enable does
        cnt_q <= cnt_q - UL_CNT_W'(1);
      end
    end
  end

  assign unlock_o = (cnt_q != '0);
  assign count_o  = cnt_q;

  property p_key_sets;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && key_match |=> unlock_o && count_o == 4'h8;
  endproperty
  a_key_sets: assert property (p_key_sets) else $error("unlock not armed");

  property p_window_ends;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && !key_match && cnt_q == 4'h1 && instr_cycle_i && !freeze_i
      |=> !unlock_o;
  endproperty
  a_window_ends: assert property (p_window_ends) else $error("window overran");

  property p_freeze;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && freeze_i && !key_match |=> $stable(cnt_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("count moved in breakpoint");

  property p_miss_keeps;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && wr_i && !key_match && !unlock_o |=> !unlock_o;
  endproperty
  a_miss_keeps: assert property (p_miss_keeps) else $error("bad key armed");
endmodule
`default_nettype wire

/* logic/ibec_pulse.sv */
`timescale 1ns/10ps
`default_nettype none
module ibec_pulse (
  input  wire logic                        clk_sys_i, // system clock
  input  wire logic                        reset_i,   // sync reset
  input  wire logic                        clk_en_i,  // clock enable
  input  wire logic                        start_i,   // write or erase start
  input  wire logic [ibec_pkg::TIM_W-1:0]  timing_i,  // pulse timing value
  output logic                             busy_o,    // pulse in progress
  output logic                             pulse_o,   // flash timing pulse
  output logic                             done_o     // one-cycle end mark
);
  import ibec_pkg::*;

  ibec_pulse_st_t         st_q;
  logic [PULSE_CNT_W-1:0] cnt_q;
  logic [PULSE_CNT_W-1:0] load_val;
  logic                   done_q;
  logic [PULSE_CNT_W-1:0] wid_q;
  logic [PULSE_CNT_W-1:0] exp_q;

  // width scales with the timing value
  assign load_val = PULSE_CNT_W'(timing_i) << PULSE_SHIFT;

  // value is captured at start, so a mid-operation write cannot stretch it
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q   <= IBEC_PL_IDLE;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (clk_en_i) begin
      done_q <= 1'b0;
      case (st_q)
        IBEC_PL_IDLE: begin
          if (start_i) begin
            cnt_q <= load_val;
            if (load_val != '0) begin
              st_q <= IBEC_PL_ACTIVE;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        IBEC_PL_ACTIVE: begin
          cnt_q <= cnt_q - PULSE_CNT_W'(1);
          if (cnt_q == PULSE_CNT_W'(1)) begin
            st_q   <= IBEC_PL_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= IBEC_PL_IDLE;
      endcase
    end
  end

  assign pulse_o = st_q[1];
  assign busy_o  = st_q[1];
  assign done_o  = done_q;

  // helper: measured width against the width captured at start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wid_q <= '0;
      exp_q <= '0;
    end else if (clk_en_i) begin
      if (st_q == IBEC_PL_IDLE) begin
        wid_q <= '0;
        exp_q <= load_val;
      end else begin
        wid_q <= wid_q + PULSE_CNT_W'(1);
      end
    end
  end

  property p_width;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && pulse_o && cnt_q == 12'h001 |-> wid_q + 12'h001 == exp_q;
  endproperty
  a_width: assert property (p_width) else $error("pulse width wrong");
endmodule
`default_nettype wire

/* logic/ibec_top.sv */
// Overview of operation
// - pulse width follows the timing register
// - reset loads the 10 MHz timing value
// - boot jump only while unlock bit set
// - unlock needs key 100110 in bits 7-2
// - unlock bit lasts exactly 8 instruction cycles
// - breakpoint in emulation freezes unlock count
// - interrupts do not pause the unlock window
// - return instruction goes back to flash
// - forced entry starts boot ROM at 0000
// - later unforced reset uses the select bit
// - forced entry leaves option bits untouched
// - security clears by mass erase or a user routine request
// - force level drives load clock pin
// - force pin reads one while high voltage
// - select bit one flash, zero boot ROM
`timescale 1ns/10ps
`default_nettype none
module ibec_top (
  input  wire logic                         clk_sys_i,              // system clock
  input  wire logic                         reset_i,                // sync reset
  input  wire logic                         clk_en_i,               // clock enable
  input  wire logic                         instr_cycle_i,          // instr cycle strobe
  input  wire logic                         timing_wr_i,            // timing reg write
  input  wire logic [ibec_pkg::BYTE_W-1:0]  timing_wdata_i,         // timing write data
  output logic [ibec_pkg::BYTE_W-1:0]       timing_rdata_o,         // timing read data
  input  wire logic                         unlock_wr_i,            // unlock reg write
  input  wire logic [ibec_pkg::BYTE_W-1:0]  unlock_wdata_i,         // unlock write data
  output logic                              unlock_active_o,        // unlock bit
  input  wire logic                         emul_mode_i,            // emulation mode
  input  wire logic                         breakpoint_i,           // breakpoint held
  input  wire logic                         jump_to_boot_instr_i,   // jump executes
  input  wire logic [ibec_pkg::ADDR_W-1:0]  jump_target_i,          // jump operand
  input  wire logic                         return_to_flash_instr_i,// return executes
  input  wire logic [ibec_pkg::ADDR_W-1:0]  return_target_i,        // return address
  output logic                              redirect_valid_o,       // fetch redirect
  output logic                              redirect_boot_o,        // redirect to boot
  output logic [ibec_pkg::ADDR_W-1:0]       redirect_addr_o,        // redirect address
  output logic                              mem_space_boot_o,       // fetching boot ROM
  input  wire logic                         boot_select_bit_i,      // option select bit
  input  wire logic                         force_hv_i,             // force pin at HV
  input  wire logic                         force_boot_pin_i,       // force pin level
  output logic                              force_boot_rd_o,        // force pin as read
  output logic                              start_valid_o,          // start chosen
  output logic                              start_boot_o,           // start in boot
  output logic [ibec_pkg::ADDR_W-1:0]       start_addr_o,           // start address
  input  wire logic                         load_clock_pin_i,       // pin input
  output logic                              load_clock_pin_o,       // pin output
  output logic                              load_clock_pin_oe_o,    // pin drive enable
  input  wire logic                         gpio_load_out_i,        // port data out
  input  wire logic                         gpio_load_oe_i,         // port drive enable
  output logic                              gpio_load_rd_o,         // port read value
  input  wire logic                         flash_op_start_i,       // write/erase start
  output logic                              flash_pulse_o,          // timing pulse
  output logic                              flash_busy_o,           // operation busy
  output logic                              flash_done_o,           // operation done
  input  wire logic                         mass_erase_i,           // mass erase done
  input  wire logic                         user_isp_mode_i,        // user routine active
  input  wire logic                         security_clr_req_i,     // clear request
  output logic                              security_clr_o          // clear security
);
  import ibec_pkg::*;

  logic [TIM_W-1:0]    timing_q;
  logic                unlock_bit;
  logic                bp_freeze;
  ibec_start_st_t      st_q;
  logic                start_valid_q;
  logic                start_boot_q;
  logic                mem_boot_q;
  logic                redir_valid_q;
  logic                redir_boot_q;
  logic [ADDR_W-1:0]   redir_addr_q;
  logic [LDCLK_W-1:0]  ldclk_cnt_q;
  logic                ldclk_q;
  logic                pin_o_q;
  logic                pin_oe_q;
  logic                pin_rd_q;
  logic                force_rd_q;
  logic                sec_clr_q;

  // timing register; reset loads the 10 MHz value, pulses capture it at start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      timing_q <= TIMING_RESET;
    end else if (clk_en_i && timing_wr_i) begin
      timing_q <= timing_wdata_i & TIMING_WMASK;
    end
  end

  assign timing_rdata_o = timing_q;

  // breakpoints only stall the window while emulating
  assign bp_freeze = emul_mode_i && breakpoint_i;

  // unlock window; no interrupt input on purpose, so isr time still counts
  ibec_unlock u_unlock (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .clk_en_i      (clk_en_i),
    .wr_i          (unlock_wr_i),
    .wdata_i       (unlock_wdata_i),
    .instr_cycle_i (instr_cycle_i),
    .freeze_i      (bp_freeze),
    .unlock_o      (unlock_bit),
    .count_o       ()
  );

  assign unlock_active_o = unlock_bit;

  // write and erase pulse timing
  ibec_pulse u_pulse (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .start_i   (flash_op_start_i),
    .timing_i  (timing_q),
    .busy_o    (flash_busy_o),
    .pulse_o   (flash_pulse_o),
    .done_o    (flash_done_o)
  );

  // start memory chosen on the first enabled cycle after reset release;
  // the host keeps the force level for a few cycles, so one sample is safe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_q          <= IBEC_ST_SAMPLE;
      start_valid_q <= 1'b0;
      start_boot_q  <= 1'b0;
    end else if (clk_en_i) begin
      start_valid_q <= 1'b0;
      case (st_q)
        IBEC_ST_SAMPLE: begin
          // force bypasses the select bit; option bits are only read here
          start_boot_q  <= force_hv_i || !boot_select_bit_i;
          start_valid_q <= 1'b1;
          st_q          <= IBEC_ST_RUN;
        end
        IBEC_ST_RUN: begin
          st_q <= IBEC_ST_RUN;
        end
        default: st_q <= IBEC_ST_SAMPLE;
      endcase
    end
  end

  assign start_valid_o = start_valid_q;
  assign start_boot_o  = start_boot_q;
  assign start_addr_o  = START_ADDR;

  // fetch space and redirects; jump wins when both instructions coincide
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mem_boot_q    <= 1'b0;
      redir_valid_q <= 1'b0;
      redir_boot_q  <= 1'b0;
      redir_addr_q  <= START_ADDR;
    end else if (clk_en_i) begin
      redir_valid_q <= 1'b0;
      if (st_q == IBEC_ST_SAMPLE) begin
        mem_boot_q <= force_hv_i || !boot_select_bit_i;
      end else if (jump_to_boot_instr_i) begin
        // a locked jump stays in flash, guarding against runaway code
        mem_boot_q    <= unlock_bit;
        redir_valid_q <= 1'b1;
        redir_boot_q  <= unlock_bit;
        redir_addr_q  <= jump_target_i;
      end else if (return_to_flash_instr_i) begin
        mem_boot_q    <= 1'b0;
        redir_valid_q <= 1'b1;
        redir_boot_q  <= 1'b0;
        redir_addr_q  <= return_target_i;
      end
    end
  end

  assign mem_space_boot_o = mem_boot_q;
  assign redirect_valid_o = redir_valid_q;
  assign redirect_boot_o  = redir_boot_q;
  assign redirect_addr_o  = redir_addr_q;

  // load clock divider, free running so the shift clock is always ready
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ldclk_cnt_q <= '0;
      ldclk_q     <= 1'b0;
    end else if (clk_en_i) begin
      if (ldclk_cnt_q == LDCLK_HALF) begin
        ldclk_cnt_q <= '0;
        ldclk_q     <= !ldclk_q;
      end else begin
        ldclk_cnt_q <= ldclk_cnt_q + LDCLK_W'(1);
      end
    end
  end

  // pin mux; the forced clock can fight an external shift clock, user beware
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pin_o_q  <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_rd_q <= 1'b0;
    end else if (clk_en_i) begin
      pin_o_q  <= force_hv_i ? ldclk_q : gpio_load_out_i;
      pin_oe_q <= force_hv_i || gpio_load_oe_i;
      pin_rd_q <= load_clock_pin_i;
    end
  end

  assign load_clock_pin_o    = pin_o_q;
  assign load_clock_pin_oe_o = pin_oe_q;
  assign gpio_load_rd_o      = pin_rd_q;

  // high voltage reads as one; boot code debounces the fall itself
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      force_rd_q <= 1'b0;
    end else if (clk_en_i) begin
      force_rd_q <= force_hv_i || force_boot_pin_i;
    end
  end

  assign force_boot_rd_o = force_rd_q;

  // security clear: mass erase, or a request from user routines
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sec_clr_q <= 1'b0;
    end else if (clk_en_i) begin
      sec_clr_q <= mass_erase_i || (security_clr_req_i && user_isp_mode_i);
    end
  end

  assign security_clr_o = sec_clr_q;

  property p_reset_timing;
    @(posedge clk_sys_i) $fell(reset_i) |-> timing_rdata_o == 8'h7B;
  endproperty
  a_reset_timing: assert property (p_reset_timing) else $error("timing reset");

  property p_force_start;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && st_q == IBEC_ST_SAMPLE && force_hv_i
      |=> start_valid_o && start_boot_o && start_addr_o == 16'h0000;
  endproperty
  a_force_start: assert property (p_force_start) else $error("forced start");

  property p_select_start;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && st_q == IBEC_ST_SAMPLE && !force_hv_i
      |=> start_boot_o == !$past(boot_select_bit_i) && mem_space_boot_o == start_boot_o;
  endproperty
  a_select_start: assert property (p_select_start) else $error("select start");

  property p_start_held;
    @(posedge clk_sys_i) disable iff (reset_i)
      st_q == IBEC_ST_RUN |=> $stable(start_boot_o) && !start_valid_o;
  endproperty
  a_start_held: assert property (p_start_held) else $error("start changed");

  property p_locked_jump;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && st_q == IBEC_ST_RUN && jump_to_boot_instr_i && !unlock_bit
      |=> redirect_valid_o && !redirect_boot_o && !mem_space_boot_o;
  endproperty
  a_locked_jump: assert property (p_locked_jump) else $error("locked jump");

  property p_open_jump;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && st_q == IBEC_ST_RUN && jump_to_boot_instr_i && unlock_bit
      |=> redirect_boot_o && redirect_addr_o == $past(jump_target_i);
  endproperty
  a_open_jump: assert property (p_open_jump) else $error("open jump");

  property p_return;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && st_q == IBEC_ST_RUN && return_to_flash_instr_i && !jump_to_boot_instr_i
      |=> redirect_valid_o && !mem_space_boot_o;
  endproperty
  a_return: assert property (p_return) else $error("return to flash");

  property p_load_clock;
    @(posedge clk_sys_i) disable iff (reset_i)
      clk_en_i && force_hv_i |=> load_clock_pin_oe_o && force_boot_rd_o;
  endproperty
  a_load_clock: assert property (p_load_clock) else $error("load clock pin");

  property p_sec_clear;
    @(posedge clk_sys_i) disable iff (reset_i)
      security_clr_o && $past(clk_en_i)
      |-> $past(mass_erase_i || (security_clr_req_i && user_isp_mode_i));
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security clear");
endmodule
`default_nettype wire

/* tb/ibec_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ibec_host (
  input  wire logic clk_sys_i,  // system clock
  output logic      reset_o,    // device reset
  output logic      force_hv_o, // force pin at high voltage
  output logic      force_pin_o // force pin level, isolated
);
  import ibec_pkg::*;
  // pin is cut off from its data source, so it rests low
  initial begin
    force_hv_o = 1'b0;
    force_pin_o = 1'b0;
  end
  // reset first, force level set inside reset and kept, then release
  task automatic apply_reset(input logic forced, input int cycles);
    reset_o = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    force_hv_o = forced;
    repeat (cycles) @(negedge clk_sys_i);
    reset_o = 1'b0;
  endtask
  // level is held past release; device samples it once for the start choice
  task automatic drop_force();
    repeat (FORCE_HOLD_CYCLES + 1) @(negedge clk_sys_i);
    force_hv_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ibec_pkg::*;
  logic clk_sys_i, reset_i, hv, fpin, instr, t_wr, u_wr, emul, bkpt, jmp, ret, sel;
  logic fop, merase, umode, sreq, tie0, rv, rb, msb, frd, sv, sb, lco, lcoe;
  logic uact, fpl, fdone, sclr, lv, fbusy, grd, cen;
  logic [7:0]  t_wd, u_wd, t_rd;
  logic [15:0] jt, rt, raddr, saddr;
  int bad_count, n_checks, cyc, n;

  ibec_host ibec_host_i (.clk_sys_i(clk_sys_i), .reset_o(reset_i), .force_hv_o(hv),
    .force_pin_o(fpin));

  ibec_top ibec_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(cen),
    .instr_cycle_i(instr), .timing_wr_i(t_wr), .timing_wdata_i(t_wd),
    .timing_rdata_o(t_rd), .unlock_wr_i(u_wr), .unlock_wdata_i(u_wd),
    .unlock_active_o(uact), .emul_mode_i(emul), .breakpoint_i(bkpt),
    .jump_to_boot_instr_i(jmp), .jump_target_i(jt), .return_to_flash_instr_i(ret),
    .return_target_i(rt), .redirect_valid_o(rv), .redirect_boot_o(rb),
    .redirect_addr_o(raddr), .mem_space_boot_o(msb), .boot_select_bit_i(sel),
    .force_hv_i(hv), .force_boot_pin_i(fpin), .force_boot_rd_o(frd),
    .start_valid_o(sv), .start_boot_o(sb), .start_addr_o(saddr),
    .load_clock_pin_i(lco & lcoe), .load_clock_pin_o(lco), .load_clock_pin_oe_o(lcoe),
    .gpio_load_out_i(tie0), .gpio_load_oe_i(tie0), .gpio_load_rd_o(grd),
    .flash_op_start_i(fop), .flash_pulse_o(fpl), .flash_busy_o(fbusy), .flash_done_o(fdone),
    .mass_erase_i(merase), .user_isp_mode_i(umode), .security_clr_req_i(sreq),
    .security_clr_o(sclr));

  // free running 250 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask

  // strobe is left high afterwards, so calls in a row never glitch it; a write lowers it
  task automatic strobes(input int k);
    instr = 1'b1;
    tick(k);
  endtask

  task automatic wr_unlock(input logic [7:0] d);
    instr = 1'b0;
    u_wr = 1'b1;
    u_wd = d;
    tick(1);
    u_wr = 1'b0;
  endtask

  task automatic wr_timing(input logic [7:0] d);
    t_wr = 1'b1;
    t_wd = d;
    tick(1);
    t_wr = 1'b0;
  endtask

  // jump or return, then look at the one-cycle redirect
  task automatic xfer(input logic j, input logic [15:0] a);
    if (j) begin
      jmp = 1'b1;
      jt = a;
    end else begin
      ret = 1'b1;
      rt = a;
    end
    tick(1);
    jmp = 1'b0;
    ret = 1'b0;
    check("redirect_valid", 16'(rv), 16'h0001);
    check("redirect_addr", raddr, a);
  endtask

  // reset, then confirm the start choice in the cycle it is posted
  task automatic restart(input logic forced, input logic s, input logic exp_boot);
    sel = s;
    ibec_host_i.apply_reset(forced, 18);
    tick(1);
    check("start_valid", 16'(sv), 16'h0001);
    check("start_boot", 16'(sb), 16'(exp_boot));
    check("start_addr", saddr, START_ADDR);
    check("timing", 16'(t_rd), 16'h007B);
  endtask

  // hang guard, well above the length of the sequence
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    {instr, t_wr, u_wr, emul, bkpt, jmp, ret, fop, merase, umode, sreq, tie0} = '0;
    {t_wd, u_wd, jt, rt} = '0;
    sel = 1'b1;
    cen = 1'b1;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    restart(1'b0, 1'b1, 1'b0);
    // flash pulse width: bit 7 dropped, 16 clocks per count
    wr_timing(8'hFF);
    check("timing", 16'(t_rd), 16'h007F);
    tick(1);
    wr_timing(8'h02);
    // two operations on a single load of the timing value
    repeat (2) begin
      fop = 1'b1;
      tick(1);
      fop = 1'b0;
      check("flash_busy", 16'(fbusy), 16'h0001);
      n = 0;
      while (fpl === 1'b1 && n < 100) begin
        n++;
        tick(1);
      end
      check("pulse_len", 16'(n), 16'd32);
      check("flash_done", 16'(fdone), 16'h0001);
    end
    // wrong key refused, jump stays in flash
    wr_unlock(8'h94);
    check("unlock", 16'(uact), 16'h0000);
    xfer(1'b1, 16'h0123);
    check("redirect_boot", 16'(rb), 16'h0000);
    // window of exactly eight cycles, low bits ignored
    wr_unlock(8'h9B);
    check("unlock", 16'(uact), 16'h0001);
    strobes(7);
    check("unlock", 16'(uact), 16'h0001);
    strobes(1);
    check("unlock", 16'(uact), 16'h0000);
    // rewrite mid-window restarts the count
    wr_unlock(8'h98);
    strobes(4);
    wr_unlock(8'h98);
    strobes(7);
    check("unlock", 16'(uact), 16'h0001);
    strobes(1);
    check("unlock", 16'(uact), 16'h0000);
    // breakpoint freezes only in emulation mode
    wr_unlock(8'h98);
    emul = 1'b1;
    bkpt = 1'b1;
    strobes(12);
    check("unlock", 16'(uact), 16'h0001);
    emul = 1'b0;
    strobes(8);
    check("unlock", 16'(uact), 16'h0000);
    bkpt = 1'b0;
    // clock enable low freezes the window
    wr_unlock(8'h98);
    cen = 1'b0;
    strobes(10);
    cen = 1'b1;
    check("unlock", 16'(uact), 16'h0001);
    strobes(8);
    check("unlock", 16'(uact), 16'h0000);
    // unlocked jump enters boot, return goes back
    wr_unlock(8'h98);
    xfer(1'b1, 16'h0321);
    check("redirect_boot", 16'(rb), 16'h0001);
    check("mem_space", 16'(msb), 16'h0001);
    tick(1);
    check("redirect_valid", 16'(rv), 16'h0000);
    xfer(1'b0, 16'h0456);
    check("mem_space", 16'(msb), 16'h0000);
    // security clear paths
    merase = 1'b1;
    tick(1);
    merase = 1'b0;
    check("security_clr", 16'(sclr), 16'h0001);
    sreq = 1'b1;
    tick(1);
    check("security_clr", 16'(sclr), 16'h0000);
    umode = 1'b1;
    tick(1);
    sreq = 1'b0;
    check("security_clr", 16'(sclr), 16'h0001);
    // forced entry overrides select bit, load clock runs
    restart(1'b1, 1'b1, 1'b1);
    check("force_rd", 16'(frd), 16'h0001);
    check("load_clk_oe", 16'(lcoe), 16'h0001);
    lv = lco;
    n = 0;
    while (lco === lv && n < 20) begin
      n++;
      tick(1);
    end
    check("load_clk_toggle", 16'(n < 20), 16'h0001);
    tick(1);
    check("pin_read", 16'(grd), 16'(lco));
    ibec_host_i.drop_force();
    tick(2);
    check("force_rd", 16'(frd), 16'h0000);
    check("load_clk_oe", 16'(lcoe), 16'h0000);
    restart(1'b0, 1'b1, 1'b0);
    restart(1'b0, 1'b0, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
